// ---- ila_map.vh ----
`ifndef ILA_MAP_VH
`define ILA_MAP_VH
// beat counter and stack offset
`define ILA_CNT_START 3'h0
`define ILA_CNT_STEP 3'h1
`define ILA_OFF_FIRST 3'h0
// interrupt mask value out of reset
`define ILA_MASK_RST 1'b1
// bus cycle kinds shown to the core
`define ILA_CYC_NONE 2'h0
`define ILA_CYC_PUSH 2'h1
`define ILA_CYC_PULL 2'h2
`define ILA_CYC_VEC 2'h3
// stacked registers: pcl, pch, x, a, ccr (index high byte left out)
`define ILA_STACK_BYTES 3'h5
`define ILA_VECL_SEL 1'b1
`define ILA_VECH_SEL 1'b0
// code reserved for the software interrupt instruction
`define ILA_CODE_SWI 5'h00
`endif

// ---- ila_interrupt_latch_arbiter.v ----
// Contract
// RL1: entry pushes core registers to stack and sets interrupt mask.
// RL2: return instruction pulls core registers back from stack.
// RL3: requests latched; arbitration only when interrupt processing starts.
// RL4: winner presented as fixed source code selecting vector to fetch.
// RL5: latched choice held against all others until serviced or mask clears.
// RL6: software interrupt enters regardless of mask; hardware ones maskable.
// RL7: hardware interrupt starts only at instruction boundary.
// RL8: proceed only if mask clear and source enabled; else continue.
// RL9: highest priority pending request wins at boundary.
// RL10: index high byte is never pushed on entry.
// RL11: pushes at decreasing addresses, then vector high then low read.
`timescale 1ns/1ps
`default_nettype none
`include "ila_map.vh"
module ila_interrupt_latch_arbiter #(
  parameter NSRC = 16,
  parameter CW = 5
) (
  // clock and reset
  input wire mclk_i,
  input wire reset_i,
  // peripheral sources, bit 0 highest priority
  input wire [NSRC-1:0] irq_req_i,
  input wire [NSRC-1:0] irq_en_i,
  // core status
  input wire instr_done_i,
  input wire swi_exec_i,
  input wire rti_exec_i,
  input wire cli_i,
  input wire bus_ack_i,
  // core control
  output reg busy_o,
  output reg hold_core_o,
  output reg mask_o,
  output reg [CW-1:0] vec_code_o,
  output reg [1:0] cyc_kind_o,
  output reg [2:0] stack_off_o,
  output reg vec_byte_o,
  output reg entry_done_o,
  output reg return_done_o
);
  // sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_PUSH = 3'h1;
  localparam ST_VECH = 3'h2;
  localparam ST_VECL = 3'h3;
  localparam ST_SERV = 3'h4;
  localparam ST_PULL = 3'h5;
  reg [NSRC-1:0] pend_r;
  reg latched_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [2:0] cnt_r;
  reg [CW-1:0] win_code;
  reg win_any;
  integer k;
  wire [NSRC-1:0] live = pend_r & irq_en_i;
  wire take_hw = instr_done_i & ~mask_o & win_any; // RL7 RL8
  wire take_sw = instr_done_i & swi_exec_i; // RL6
  wire take_rti = instr_done_i & rti_exec_i & (st_r == ST_SERV);
  wire last = (cnt_r == `ILA_STACK_BYTES - `ILA_CNT_STEP);

  // sequencer events: entry start at a boundary, then one per accepted bus beat
  wire entry_go = (st_r == ST_IDLE || (st_r == ST_SERV && !take_rti)) &&
    (take_sw || take_hw);
  wire push_ack = (st_r == ST_PUSH) && bus_ack_i;
  wire pull_ack = (st_r == ST_PULL) && bus_ack_i;
  wire vech_ack = (st_r == ST_VECH) && bus_ack_i;
  wire vecl_ack = (st_r == ST_VECL) && bus_ack_i;
  wire push_end = push_ack && last;
  wire pull_end = pull_ack && last;

  // fixed priority encoder, bit 0 wins
  always @* begin
    win_code = {CW{1'b0}};
    win_any = 1'b0;
    for (k = NSRC-1; k >= 0; k = k - 1) begin
      if (live[k]) begin
        win_code = k[CW-1:0] + {{(CW-1){1'b0}}, 1'b1}; // RL9
        win_any = 1'b1;
      end
    end
  end

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (take_sw || take_hw) begin
          st_nxt = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (bus_ack_i && last) begin
          st_nxt = ST_VECH;
        end
      end
      ST_VECH: begin
        if (bus_ack_i) begin
          st_nxt = ST_VECL; // RL11
        end
      end
      ST_VECL: begin
        if (bus_ack_i) begin
          st_nxt = ST_SERV;
        end
      end
      ST_SERV: begin
        if (take_rti) begin
          st_nxt = ST_PULL;
        end else if (take_sw || take_hw) begin
          st_nxt = ST_PUSH;
        end
      end
      ST_PULL: begin
        if (bus_ack_i && last) begin
          st_nxt = ST_IDLE; // RL2
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // sequencer state and beat counter
  always @(posedge mclk_i) begin
    if (reset_i) begin
      st_r <= ST_IDLE;
      cnt_r <= `ILA_CNT_START;
    end else begin
      st_r <= st_nxt;
      if (entry_go || take_rti) begin
        cnt_r <= `ILA_CNT_START;
      end else if (push_ack || pull_ack) begin
        cnt_r <= cnt_r + `ILA_CNT_STEP;
      end
    end
  end

  // request capture, mask and the frozen arbitration result
  always @(posedge mclk_i) begin
    if (reset_i) begin
      pend_r <= {NSRC{1'b0}};
      latched_r <= 1'b0;
      mask_o <= `ILA_MASK_RST;
      vec_code_o <= {CW{1'b0}};
    end else begin
      // requests stay latched until their level drops
      pend_r <= irq_req_i; // RL3
      if (cli_i) begin
        mask_o <= 1'b0;
        latched_r <= 1'b0; // RL5
      end
      // entry start: arbitrate once, set wins over a clear in one cycle
      if (entry_go) begin
        if (!latched_r) begin
          vec_code_o <= take_sw ? `ILA_CODE_SWI : win_code; // RL3 RL4 RL6
          latched_r <= 1'b1;
        end
        mask_o <= 1'b1; // RL1
      end
      if (pull_end) begin
        mask_o <= 1'b0; // RL2
      end
      if (vecl_ack) begin
        latched_r <= 1'b0; // RL5
      end
    end
  end

  // busy, core hold and completion pulses
  always @(posedge mclk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
      hold_core_o <= 1'b0;
      entry_done_o <= 1'b0;
      return_done_o <= 1'b0;
    end else begin
      entry_done_o <= vecl_ack;
      return_done_o <= pull_end;
      if (entry_go || take_rti) begin
        busy_o <= 1'b1;
        hold_core_o <= 1'b1; // RL7
      end else if (vecl_ack || pull_end) begin
        busy_o <= 1'b0;
        hold_core_o <= 1'b0;
      end
    end
  end

  // bus cycle kind, stack offset and vector byte select
  always @(posedge mclk_i) begin
    if (reset_i) begin
      cyc_kind_o <= `ILA_CYC_NONE;
      stack_off_o <= `ILA_OFF_FIRST;
      vec_byte_o <= `ILA_VECH_SEL;
    end else begin
      if (entry_go) begin
        cyc_kind_o <= `ILA_CYC_PUSH; // RL1 RL10
        stack_off_o <= `ILA_OFF_FIRST;
      end
      if (take_rti) begin
        cyc_kind_o <= `ILA_CYC_PULL; // RL2
        stack_off_o <= `ILA_STACK_BYTES - `ILA_CNT_STEP;
      end
      if (push_ack) begin
        stack_off_o <= cnt_r + `ILA_CNT_STEP; // RL11
      end
      if (pull_ack) begin
        stack_off_o <= stack_off_o - `ILA_CNT_STEP;
      end
      if (push_end) begin
        cyc_kind_o <= `ILA_CYC_VEC;
        vec_byte_o <= `ILA_VECH_SEL; // RL11
      end
      if (vech_ack) begin
        vec_byte_o <= `ILA_VECL_SEL; // RL11
      end
      if (vecl_ack || pull_end) begin
        cyc_kind_o <= `ILA_CYC_NONE;
      end
    end
  end
endmodule
`default_nettype wire

// ---- ila_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ila_core_model (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [1:0] cyc_kind_i,
  output var logic bus_ack_o = 1'b0
);
  // finishes each shown bus cycle a cycle late, then rests a cycle
  always @(posedge mclk_i)
    bus_ack_o <= !reset_i && cyc_kind_i != 2'h0 && !bus_ack_o;
endmodule
`default_nettype wire

// ---- ila_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ila_checker #(
  parameter CW = 5
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // core status
  input wire logic instr_done_i,
  input wire logic swi_exec_i,
  input wire logic rti_exec_i,
  input wire logic cli_i,
  input wire logic bus_ack_i,
  // block outputs
  input wire logic busy_o,
  input wire logic mask_o,
  input wire logic vec_byte_o,
  input wire logic entry_done_o,
  input wire logic return_done_o,
  input wire logic [CW-1:0] vec_code_o,
  input wire logic [1:0] cyc_kind_o,
  input wire logic [2:0] stack_off_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire push_ack = cyc_kind_o == 2'h1 && bus_ack_i;
  wire idle_bnd = instr_done_i && !rti_exec_i && !busy_o;
  swi_take_a: assert property (idle_bnd && swi_exec_i |=> busy_o &&
    cyc_kind_o == 2'h1 && stack_off_o == 3'h0) else $error("no entry");
  entry_mask_a: assert property (entry_done_o |-> mask_o)
    else $error("mask clear");
  mask_block_a: assert property (idle_bnd && !swi_exec_i && mask_o
    |=> !busy_o) else $error("masked entry");
  push_step_a: assert property (push_ack && stack_off_o < 3'h4
    |=> stack_off_o == $past(stack_off_o) + 3'h1) else $error("push order");
  push_last_a: assert property (push_ack && stack_off_o == 3'h4
    |=> cyc_kind_o == 2'h3 && !vec_byte_o) else $error("push count");
  vec_pair_a: assert property (cyc_kind_o == 2'h3 && bus_ack_i
    && !vec_byte_o |=> cyc_kind_o == 2'h3 && vec_byte_o) else $error("vec");
  code_hold_a: assert property (cyc_kind_o == 2'h1 && !cli_i
    |=> $stable(vec_code_o)) else $error("code moved");
  ret_done_a: assert property (cyc_kind_o == 2'h2 && bus_ack_i
    && stack_off_o == 3'h0 |-> ##[1:2] return_done_o) else $error("no ret");
endmodule
bind ila_interrupt_latch_arbiter ila_checker #(.CW(CW)) u_ila_checker (
  .mclk_i(mclk_i), .reset_i(reset_i), .instr_done_i(instr_done_i),
  .swi_exec_i(swi_exec_i), .rti_exec_i(rti_exec_i), .cli_i(cli_i),
  .bus_ack_i(bus_ack_i), .busy_o(busy_o), .mask_o(mask_o),
  .vec_byte_o(vec_byte_o), .entry_done_o(entry_done_o),
  .return_done_o(return_done_o), .vec_code_o(vec_code_o),
  .cyc_kind_o(cyc_kind_o), .stack_off_o(stack_off_o));
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i = 0, reset_i = 1, instr_done_i = 0, swi_exec_i = 0;
  logic rti_exec_i = 0, cli_i = 0;
  logic [15:0] irq_req_i = 0, irq_en_i = 16'hffff;
  wire bus_ack_i, busy_o, hold_core_o, mask_o, vec_byte_o;
  wire entry_done_o, return_done_o;
  wire [4:0] vec_code_o;
  wire [1:0] cyc_kind_o;
  wire [2:0] stack_off_o;
  int fails = 0, compares = 0, n;
  logic [4:0] code;
  always #12.5 mclk_i = ~mclk_i;
  ila_interrupt_latch_arbiter u_ila_interrupt_latch_arbiter (
    .mclk_i(mclk_i), .reset_i(reset_i), .irq_req_i(irq_req_i),
    .irq_en_i(irq_en_i), .instr_done_i(instr_done_i),
    .swi_exec_i(swi_exec_i), .rti_exec_i(rti_exec_i), .cli_i(cli_i),
    .bus_ack_i(bus_ack_i), .busy_o(busy_o), .hold_core_o(hold_core_o),
    .mask_o(mask_o), .vec_code_o(vec_code_o), .cyc_kind_o(cyc_kind_o),
    .stack_off_o(stack_off_o), .vec_byte_o(vec_byte_o),
    .entry_done_o(entry_done_o), .return_done_o(return_done_o));
  ila_core_model u_ila_core_model (.mclk_i, .reset_i,
    .cyc_kind_i(cyc_kind_o), .bus_ack_o(bus_ack_i));
  task chk(string s, logic [4:0] g, e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h seen %h", s, e, g);
    end
  endtask
  task close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task bnd(logic s, r);
    @(negedge mclk_i) {instr_done_i, swi_exec_i, rti_exec_i} = {1'b1, s, r};
    @(negedge mclk_i) {instr_done_i, swi_exec_i, rti_exec_i} = 3'h0;
  endtask
  // follow a sequence to its done pulse, counting pushes
  task run;
    n = 0;
    repeat (40) begin
      @(negedge mclk_i);
      if (cyc_kind_o == 2'h1 && bus_ack_i) n++;
      if (cyc_kind_o == 2'h3) code = vec_code_o;
      if (entry_done_o || return_done_o) return;
    end
    chk("done", 5'h00, 5'h01);
  endtask
  task t_swi;
    bnd(1, 0);
    chk("hold", hold_core_o, 5'h01);
    run;
    chk("swi code", code, 5'h00);
    chk("pushes", n[4:0], 5'h05);
    chk("mask", mask_o, 5'h01);
    chk("free", hold_core_o, 5'h00);
  endtask
  task t_ret;
    bnd(0, 1);
    run;
    @(negedge mclk_i);
    chk("ret mask", mask_o, 5'h00);
  endtask
  // disabled source ignored, bit 1 beats bit 3, late bit 0 waits
  task t_prio;
    irq_req_i = 16'h0020;
    irq_en_i = 16'hffdf;
    bnd(0, 0);
    bnd(0, 0);
    chk("off src", busy_o, 5'h00);
    irq_req_i = 16'h002a;
    bnd(0, 0);
    irq_req_i[0] = 1'b1;
    run;
    chk("hw code", code, 5'h02);
    bnd(0, 0);
    bnd(0, 0);
    chk("masked", busy_o, 5'h00);
  endtask
  // mask cleared in service: new arbitration, bit 0 now wins
  task t_cli;
    cli_i = 1;
    @(negedge mclk_i) cli_i = 0;
    chk("cli mask", mask_o, 5'h00);
    bnd(0, 0);
    chk("nest hold", hold_core_o, 5'h01);
    run;
    chk("nest code", code, 5'h01);
    chk("nest mask", mask_o, 5'h01);
  endtask
  // reset in mid entry, then masked boundary with requests pending
  task t_rst;
    bnd(1, 0);
    repeat (3) @(negedge mclk_i);
    reset_i = 1;
    repeat (2) @(negedge mclk_i);
    reset_i = 0;
    chk("rst hold", hold_core_o, 5'h00);
    chk("rst mask", mask_o, 5'h01);
    bnd(0, 0);
    chk("rst masked", busy_o, 5'h00);
  endtask
  initial begin
    repeat (3) @(negedge mclk_i);
    reset_i = 0;
    t_swi;
    t_ret;
    t_prio;
    t_cli;
    t_ret;
    t_rst;
    t_swi;
    t_ret;
    close_out;
  end
  initial begin
    #20us;
    fails++;
    close_out;
  end
endmodule
`default_nettype wire
